// *** rtl/pbs_filter.sv ***
// Purpose: Low-level qualifier, asserts after input stays low long enough
// Assumes: Input already synchronised
// Notes:   Any high level restarts the count
`timescale 1ns/10ps
module pbs_filter #(
  parameter int unsigned LEN = 1
) (
  input  wire logic clk_i,   // System clock
  input  wire logic rst_n_i, // Synchronous reset, active low
  input  wire logic d_n_i,   // Active-low level to qualify
  output logic      low_o    // High once d_n_i low for LEN cycles
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || d_n_i)
    begin
      cnt_r <= 32'h0000_0000;
      low_o <= 1'b0;
    end
    else if (cnt_r < 32'(LEN - 1))
      cnt_r <= cnt_r + 32'h0000_0001;
    else
      low_o <= 1'b1;
  end
endmodule

// *** rtl/pbs_pkg.sv ***
// Purpose: Shared constants and types for the pushbutton power sequencer
// Assumes: 50 MHz system clock
// Notes:   Times are held in their own unit, cycle counts derived from them
package pbs_pkg;
  localparam int unsigned CLK_HZ           = 50000000;
  localparam int unsigned NS_PER_CYCLE     = 1000000000 / CLK_HZ;
  localparam int unsigned TURN_ON_DB_MS    = 32;
  localparam int unsigned TURN_OFF_DB_MS   = 32;
  localparam int unsigned REQ_MIN_MS       = 32;
  localparam int unsigned BLANK_MS         = 512;
  localparam int unsigned LOCKOUT_MS       = 256;
  localparam int unsigned FORCED_BASE_MS   = 64;
  localparam int unsigned KILL_MIN_US      = 30;
  localparam int unsigned PD_CYCLES        = 16;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned TURN_ON_DB_CYC   = TURN_ON_DB_MS * CYC_PER_MS;
  localparam int unsigned TURN_OFF_DB_CYC  = TURN_OFF_DB_MS * CYC_PER_MS;
  localparam int unsigned REQ_MIN_CYC      = REQ_MIN_MS * CYC_PER_MS;
  localparam int unsigned BLANK_CYC        = BLANK_MS * CYC_PER_MS;
  localparam int unsigned LOCKOUT_CYC      = LOCKOUT_MS * CYC_PER_MS;
  localparam int unsigned FORCED_BASE_CYC  = FORCED_BASE_MS * CYC_PER_MS;
  // Shortest shutdown low that counts: round down, never below one cycle
  localparam int unsigned KILL_FILT_CYC    = (KILL_MIN_US * 1000) / NS_PER_CYCLE;
  localparam int unsigned TMR_W            = 32;

  typedef enum {
    PBS_IDLE,
    PBS_ON_QUAL,
    PBS_BLANK,
    PBS_REL_DB,
    PBS_MONITOR,
    PBS_OFF_DB,
    PBS_REQ_MIN,
    PBS_PD_TMR,
    PBS_REQ_HOLD,
    PBS_LOCKOUT
  } pbs_state_t;

  typedef struct packed {
    logic push_button_n;
    logic shutdown_n;
  } pbs_in_t;

  typedef struct packed {
    logic power_en;
    logic pd_req_n;
  } pbs_out_t;
endpackage

// *** rtl/pbs_sequencer.sv ***
// Purpose: Pushbutton power on/off sequencer with power-down request
// Assumes: Pins asynchronous to CLK_SYS_I; one clock domain
// Notes:   Long timers are parameters so simulation can shorten them
`timescale 1ns/10ps
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter bit          EN_ACTIVE_HIGH       = 1'b1,
  parameter int unsigned TURN_ON_EXTEND_CYC   = 0,
  parameter int unsigned POWER_DOWN_EXTEND_CYC = 0,
  parameter int unsigned TURN_ON_CYC          = pbs_pkg::TURN_ON_DB_CYC,
  parameter int unsigned TURN_OFF_CYC         = pbs_pkg::TURN_OFF_DB_CYC,
  parameter int unsigned REQ_CYC              = pbs_pkg::REQ_MIN_CYC,
  parameter int unsigned BLANK_LEN_CYC        = pbs_pkg::BLANK_CYC,
  parameter int unsigned LOCK_CYC             = pbs_pkg::LOCKOUT_CYC,
  parameter int unsigned FORCED_CYC           = pbs_pkg::FORCED_BASE_CYC,
  parameter int unsigned KILL_CYC             = pbs_pkg::KILL_FILT_CYC
) (
  input  wire logic CLK_SYS_I,          // 50 MHz system clock
  input  wire logic NRST_I,             // Synchronous reset, active low
  input  wire logic PUSH_BUTTON_N_I,    // Pushbutton pin, active low
  input  wire logic SHUTDOWN_N_I,       // Shutdown from processor, active low
  output logic      POWER_EN_O,         // Power enable, polarity by parameter
  output logic      PD_REQ_N_O,         // Power-down request, open drain level
  output logic      PD_REQ_N_OE_N_O     // Low while request pin is driven low
);
  import pbs_pkg::*;

  // Power-down timer runs base-excess plus 16 cycles of the extension period
  localparam int unsigned PD_PERIOD = (POWER_DOWN_EXTEND_CYC / PD_CYCLES) > 0 ?
                                      (POWER_DOWN_EXTEND_CYC / PD_CYCLES) : 1;
  localparam int unsigned PD_BASE   = FORCED_CYC - TURN_OFF_CYC - REQ_CYC;
  localparam int unsigned ON_TOTAL  = TURN_ON_CYC + TURN_ON_EXTEND_CYC;
  localparam int unsigned KILL_LEN  = KILL_CYC > 0 ? KILL_CYC : 1;

  pbs_in_t    pin_raw;
  pbs_in_t    pin_s;
  pbs_out_t   out_r;
  pbs_state_t state_r;
  pbs_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [4:0]       pd_cyc_r;
  logic [TMR_W-1:0] pd_per_r;
  logic       kill_low;
  logic       qual_rst_n;
  logic       btn_on_low;
  logic       enable_nxt;
  logic       btn_prev_r;
  logic       btn_fell;

  assign pin_raw.push_button_n = PUSH_BUTTON_N_I;
  assign pin_raw.shutdown_n    = SHUTDOWN_N_I;

  pbs_sync #(.W(2)) u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (NRST_I),
    .d_i     (pin_raw),
    .q_o     (pin_s)
  );

  // Filter restarts in every state other than idle/qualify
  assign qual_rst_n = NRST_I && (state_r == PBS_IDLE || state_r == PBS_ON_QUAL);

  pbs_filter #(.LEN(ON_TOTAL)) u_on_filt (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (qual_rst_n),
    .d_n_i   (pin_s.push_button_n),
    .low_o   (btn_on_low)
  );

  // Short glitches on shutdown are rejected
  pbs_filter #(.LEN(KILL_LEN)) u_kill_filt (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (NRST_I),
    .d_n_i   (pin_s.shutdown_n),
    .low_o   (kill_low)
  );

  // Pin idles high, so a reset value of high avoids a false press after reset
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
      btn_prev_r <= 1'b1;
    else
      btn_prev_r <= pin_s.push_button_n;
  end

  // A button still held after lockout must be released before a restart
  assign btn_fell = btn_prev_r && !pin_s.push_button_n;

  function automatic logic tmr_done(input logic [TMR_W-1:0] t, input int unsigned len);
    tmr_done = t >= TMR_W'(len > 0 ? len - 1 : 0);
  endfunction

  function automatic logic is_on(input pbs_state_t s);
    is_on = (s != PBS_IDLE) && (s != PBS_ON_QUAL) && (s != PBS_LOCKOUT);
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PBS_IDLE:
        if (btn_fell)
          state_nxt = PBS_ON_QUAL;
      PBS_ON_QUAL:
        if (pin_s.push_button_n)
          state_nxt = PBS_IDLE;
        else if (btn_on_low)
          state_nxt = PBS_BLANK;
      PBS_BLANK:
        if (tmr_done(tmr_r, BLANK_LEN_CYC))
          state_nxt = kill_low ? PBS_LOCKOUT : PBS_REL_DB;
      PBS_REL_DB:
        if (kill_low)
          state_nxt = PBS_LOCKOUT;
        else if (pin_s.push_button_n && tmr_done(tmr_r, TURN_OFF_CYC))
          state_nxt = PBS_MONITOR;
      PBS_MONITOR:
        if (kill_low)
          state_nxt = PBS_LOCKOUT;
        else if (!pin_s.push_button_n)
          state_nxt = PBS_OFF_DB;
      PBS_OFF_DB:
        if (kill_low)
          state_nxt = PBS_LOCKOUT;
        else if (pin_s.push_button_n)
          state_nxt = PBS_MONITOR;
        else if (tmr_done(tmr_r, TURN_OFF_CYC))
          state_nxt = PBS_REQ_MIN;
      PBS_REQ_MIN:
        if (kill_low)
          state_nxt = PBS_LOCKOUT;
        else if (tmr_done(tmr_r, REQ_CYC))
          state_nxt = pin_s.push_button_n ? PBS_REL_DB : PBS_PD_TMR;
      PBS_PD_TMR:
        if (kill_low)
          state_nxt = PBS_LOCKOUT;
        else if (pin_s.push_button_n)
          state_nxt = PBS_REL_DB;
        else if (tmr_done(tmr_r, PD_BASE) && pd_cyc_r == 5'(PD_CYCLES))
          state_nxt = PBS_REQ_HOLD;
      PBS_REQ_HOLD:
        state_nxt = PBS_LOCKOUT;
      PBS_LOCKOUT:
        if (tmr_done(tmr_r, LOCK_CYC))
          state_nxt = PBS_IDLE;
      default:
        state_nxt = PBS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
      state_r <= PBS_IDLE;
    else
      state_r <= state_nxt;
  end

  // Shared interval timer restarts on every state change; a held button
  // also restarts it in PBS_REL_DB, so the release must stay high for the whole debounce
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I || state_nxt != state_r ||
        (state_r == PBS_REL_DB && !pin_s.push_button_n))
      tmr_r <= '0;
    else if (!tmr_done(tmr_r, 32'hFFFF_FFFF))
      tmr_r <= tmr_r + TMR_W'(1);
  end

  // Extension period counter, 16 periods after the fixed base
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I || state_r != PBS_PD_TMR)
    begin
      pd_per_r <= '0;
      pd_cyc_r <= 5'h00;
    end
    else if (!tmr_done(tmr_r, PD_BASE))
    begin
      pd_per_r <= '0;
    end
    else if (POWER_DOWN_EXTEND_CYC == 0)
      pd_cyc_r <= 5'(PD_CYCLES);
    else if (pd_cyc_r != 5'(PD_CYCLES))
    begin
      if (pd_per_r >= TMR_W'(PD_PERIOD - 1))
      begin
        pd_per_r <= '0;
        pd_cyc_r <= pd_cyc_r + 5'h01;
      end
      else
        pd_per_r <= pd_per_r + TMR_W'(1);
    end
  end

  assign enable_nxt = is_on(state_nxt) && state_nxt != PBS_REQ_HOLD;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
    begin
      out_r.power_en <= 1'b0;
      out_r.pd_req_n <= 1'b1;
    end
    else
    begin
      out_r.power_en <= enable_nxt;
      out_r.pd_req_n <= !(state_nxt == PBS_REQ_MIN || state_nxt == PBS_PD_TMR);
    end
  end

  assign POWER_EN_O      = EN_ACTIVE_HIGH ? out_r.power_en : !out_r.power_en;
  assign PD_REQ_N_O      = 1'b0;
  assign PD_REQ_N_OE_N_O = out_r.pd_req_n;

  logic [TMR_W-1:0] blank_cnt_r;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I || !out_r.power_en)
      blank_cnt_r <= '0;
    else if (blank_cnt_r != '1)
      blank_cnt_r <= blank_cnt_r + TMR_W'(1);
  end

  sequence s_on_rise;
    !out_r.power_en ##1 out_r.power_en;
  endsequence

  a_reset_off: assert property (@(posedge CLK_SYS_I)
    !NRST_I |=> !out_r.power_en && out_r.pd_req_n)
    else $error("enable or request active after reset");
  a_on_qual: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    $rose(out_r.power_en) |-> $past(btn_on_low))
    else $error("enable rose without qualified press");
  a_qual_abort: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_ON_QUAL && pin_s.push_button_n |=> state_r == PBS_IDLE)
    else $error("turn-on count survived release");
  a_blank_hold: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    s_on_rise |-> state_r == PBS_BLANK)
    else $error("blanking did not start with enable");
  a_blank_ignore: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    out_r.power_en && blank_cnt_r < TMR_W'(BLANK_LEN_CYC - 2) |=> out_r.power_en)
    else $error("enable dropped inside blanking");
  a_blank_stay: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_BLANK && !tmr_done(tmr_r, BLANK_LEN_CYC) |=> state_r == PBS_BLANK)
    else $error("blanking left before its end");
  a_abort_end: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_BLANK && tmr_done(tmr_r, BLANK_LEN_CYC) && kill_low |=> !out_r.power_en)
    else $error("abort did not release enable");
  a_rel_debounce: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_REL_DB && !pin_s.push_button_n && !kill_low |=> state_r == PBS_REL_DB)
    else $error("release debounce ended while pressed");
  a_req_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_MONITOR |=> out_r.pd_req_n)
    else $error("request without debounced press");
  a_req_min: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    $fell(out_r.pd_req_n) && !kill_low |-> !out_r.pd_req_n [*8])
    else $error("request shorter than minimum");
  a_req_track: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_REQ_MIN |-> !out_r.pd_req_n)
    else $error("request not held in minimum interval");
  a_pd_early: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_PD_TMR && pd_cyc_r != 5'(PD_CYCLES) && !kill_low |=> out_r.power_en)
    else $error("enable dropped before full count");
  a_forced_off: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_REQ_HOLD |-> !out_r.power_en && out_r.pd_req_n)
    else $error("forced hold left an output active");
  a_kill_off: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_MONITOR && kill_low |=> !out_r.power_en)
    else $error("shutdown did not release enable");
  a_lockout: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_LOCKOUT |=> !out_r.power_en)
    else $error("enable during lockout");
  a_idle_edge: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_IDLE && !btn_prev_r |=> state_r != PBS_ON_QUAL)
    else $error("restart without a new press");
  a_req_keep_en: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == PBS_PD_TMR && pin_s.push_button_n && !kill_low |=> out_r.power_en)
    else $error("request release changed enable");
endmodule

// *** rtl/pbs_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs idle high after power-up
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module pbs_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_n_i, // Synchronous reset, active low
  input  wire logic [W-1:0] d_i,    // Asynchronous inputs
  output logic      [W-1:0] q_o     // Synchronised inputs
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '1;
      q_o    <= '1;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// *** tb/pbs_partner.sv ***
// Purpose: Pushbutton and processor model facing the sequencer
// Assumes: Pins change only on the falling clock edge
// Notes:   An unpowered processor holds shutdown low
`timescale 1ns/10ps
module pbs_partner (
  input  wire logic clk_i,        // System clock
  input  wire logic power_on_i,   // Enable, normalised active high
  input  wire logic req_n_i,      // Request pin level, pulled up
  output logic      button_n_o,   // Button pin, active low
  output logic      shutdown_n_o  // Shutdown pin, active low
);
  int boot_dly = 20;   // Cycles from enable to shutdown high
  int hk_dly   = 10;   // Housekeeping time after a request
  bit alive    = 1'b0; // Cleared to model a hung processor
  bit answer   = 1'b0; // Cleared to ignore the request
  initial
  begin
    button_n_o   = 1'b1;
    shutdown_n_o = 1'b0;
  end
  always @(posedge power_on_i)
  begin
    repeat (boot_dly) @(negedge clk_i);
    if (alive && power_on_i)
      shutdown_n_o = 1'b1;
  end
  always @(negedge power_on_i)
  begin
    @(negedge clk_i);
    shutdown_n_o = 1'b0;
  end
  always @(negedge req_n_i)
  begin
    repeat (hk_dly) @(negedge clk_i);
    if (answer && power_on_i)
      shutdown_n_o = 1'b0;
  end
  // Too short to count as a shutdown, so the device may ignore it
  task automatic glitch(input int n);
    shutdown_n_o = 1'b0;
    repeat (n) @(negedge clk_i);
    shutdown_n_o = 1'b1;
  endtask
endmodule

// *** tb/pushbutton_power_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the pushbutton power sequencer
// Assumes: Shortened timers; the pin latencies carry a few sync cycles
// Notes:   A second instance with inverted enable polarity runs alongside
`timescale 1ns/10ps
module pushbutton_power_sequencer_tb_top;
  import pbs_pkg::*;
  localparam int ON_C = 20;
  localparam int ON_X = 8;
  localparam int ON_T = ON_C + ON_X;
  localparam int OFF_C = 20;
  localparam int REQ_C = 20;
  localparam int BLK = 100;
  localparam int LCK = 50;
  localparam int FRC = 60;
  localparam int KIL = 3;
  logic     clk = 1'b0;
  logic     nrst = 1'b0;
  logic     btn_n, sd_n, en_hi, en_lo, req_d, oe_n, oe_n_lo, req_pin;
  pbs_in_t  pins;
  pbs_out_t outs;
  int       n_errors = 0;
  int       cmp_count = 0;
  int       t, hk;
  always #10 clk = ~clk;
  assign pins = '{push_button_n: btn_n, shutdown_n: sd_n};
  assign req_pin = oe_n ? 1'b1 : req_d;
  assign outs = '{power_en: en_hi, pd_req_n: req_pin};
  pbs_partner i_pm (.clk_i(clk), .power_on_i(en_hi), .req_n_i(req_pin),
    .button_n_o(btn_n), .shutdown_n_o(sd_n));
  pbs_sequencer #(.TURN_ON_EXTEND_CYC(ON_X), .TURN_ON_CYC(ON_C), .TURN_OFF_CYC(OFF_C),
    .REQ_CYC(REQ_C), .BLANK_LEN_CYC(BLK), .LOCK_CYC(LCK), .FORCED_CYC(FRC),
    .KILL_CYC(KIL)) i_dut (.CLK_SYS_I(clk), .NRST_I(nrst),
    .PUSH_BUTTON_N_I(pins.push_button_n), .SHUTDOWN_N_I(pins.shutdown_n),
    .POWER_EN_O(en_hi), .PD_REQ_N_O(req_d), .PD_REQ_N_OE_N_O(oe_n));
  pbs_sequencer #(.EN_ACTIVE_HIGH(1'b0), .TURN_ON_EXTEND_CYC(ON_X), .TURN_ON_CYC(ON_C),
    .TURN_OFF_CYC(OFF_C), .REQ_CYC(REQ_C), .BLANK_LEN_CYC(BLK), .LOCK_CYC(LCK),
    .FORCED_CYC(FRC), .KILL_CYC(KIL)) i_dut_lo (.CLK_SYS_I(clk), .NRST_I(nrst),
    .PUSH_BUTTON_N_I(pins.push_button_n), .SHUTDOWN_N_I(pins.shutdown_n),
    .POWER_EN_O(en_lo), .PD_REQ_N_O(), .PD_REQ_N_OE_N_O(oe_n_lo));
  task automatic fail(input string what, input int e, input int g);
    n_errors++;
    $display("FAIL %s expected %0d seen %0d", what, e, g);
  endtask
  task automatic check_en(input logic e);
    cmp_count++;
    if (outs.power_en !== e || en_lo !== ~e)
      fail("power enable", e, outs.power_en);
  endtask
  task automatic check_req(input logic e);
    cmp_count++;
    if (outs.pd_req_n !== e || oe_n_lo !== oe_n)
      fail("request", e, outs.pd_req_n);
  endtask
  task automatic check_time(input string what, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi)
      fail(what, lo, g);
  endtask
  // Counts falling edges until the watched output reaches lvl, at most lim
  task automatic wait_for(input bit on_en, input logic lvl, input int lim, output int n);
    n = 0;
    while ((on_en ? outs.power_en : outs.pd_req_n) !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail("watchdog", 0, 1);
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h2E46E604));
    hold(3);
    check_en(1'b0);
    check_req(1'b1);
    nrst = 1'b1;
    hold(4);
    $display("test reset done");
    i_pm.button_n_o = 1'b0;
    hold(ON_T - 6 - ($urandom % 8));
    i_pm.button_n_o = 1'b1;
    hold(2);
    i_pm.button_n_o = 1'b0;
    wait_for(1, 1'b1, ON_T + 10, t);
    check_time("turn-on delay", ON_T + 1, ON_T + 6, t);
    i_pm.button_n_o = 1'b1;
    wait_for(1, 1'b0, BLK + 10, t);
    check_time("abort time", BLK - 2, BLK + 4, t);
    $display("test turn-on and abort done");
    hold(LCK + 10);
    i_pm.alive = 1'b1;
    i_pm.boot_dly = 10 + $urandom % 60;
    i_pm.button_n_o = 1'b0;
    wait_for(1, 1'b1, ON_T + 10, t);
    wait_for(0, 1'b0, BLK - 6, t);
    check_time("request in blanking", BLK - 6, BLK - 6, t);
    hold(20);
    i_pm.button_n_o = 1'b1;
    check_en(1'b1);
    hold(OFF_C + 10);
    i_pm.button_n_o = 1'b0;
    hold(OFF_C - 4);
    i_pm.button_n_o = 1'b1;
    hold(6);
    check_req(1'b1);
    $display("test blanking and short press done");
    i_pm.button_n_o = 1'b0;
    wait_for(0, 1'b0, OFF_C + 10, t);
    check_time("request delay", OFF_C + 1, OFF_C + 6, t);
    i_pm.button_n_o = 1'b1;
    wait_for(0, 1'b1, REQ_C + 10, t);
    check_time("request width", REQ_C - 1, REQ_C + 4, t);
    check_en(1'b1);
    hold(OFF_C + 10);
    i_pm.button_n_o = 1'b0;
    wait_for(0, 1'b0, OFF_C + 10, t);
    hold(REQ_C + 5);
    check_req(1'b0);
    i_pm.button_n_o = 1'b1;
    wait_for(0, 1'b1, 8, t);
    check_time("request release", 0, 6, t);
    check_en(1'b1);
    hold(OFF_C + 10);
    i_pm.glitch(KIL - 2);
    hold(8);
    check_en(1'b1);
    $display("test request pulse done");
    hk = 5 + $urandom % 10;
    i_pm.hk_dly = hk;
    i_pm.answer = 1'b1;
    i_pm.button_n_o = 1'b0;
    wait_for(0, 1'b0, OFF_C + 10, t);
    i_pm.button_n_o = 1'b1;
    hold(2);
    i_pm.button_n_o = 1'b0;
    wait_for(1, 1'b0, 60, t);
    check_time("shutdown response", hk + KIL - 3, hk + KIL + 6, t);
    wait_for(1, 1'b1, LCK + ON_T + 10, t);
    check_time("restart in lockout", LCK + ON_T + 10, LCK + ON_T + 10, t);
    i_pm.button_n_o = 1'b1;
    hold(2);
    i_pm.button_n_o = 1'b0;
    wait_for(1, 1'b1, ON_T + 10, t);
    check_time("restart delay", ON_T + 1, ON_T + 6, t);
    i_pm.button_n_o = 1'b1;
    $display("test shutdown and lockout done");
    i_pm.answer = 1'b0;
    hold(BLK + OFF_C + 10);
    i_pm.button_n_o = 1'b0;
    wait_for(1, 1'b0, FRC + 12, t);
    check_time("forced off", FRC, FRC + 8, t);
    hold(2);
    check_req(1'b1);
    i_pm.button_n_o = 1'b1;
    $display("test forced off done");
    tally_and_finish();
  end
endmodule
